// ---- cdpin_top.v ----
// Purpose: pin level control and status of a cd playback signal processor
// Assumes: core clock is the crystal clock; async pins pass three flip-flops
// Notes: all outputs registered; lock pin is a three-signal two-way pin
`timescale 1ns/1ps
`include "cdpin_regs.vh"

module cdpin_top #(
	parameter LOCK_SAMPLE_CYCLES = `CDPIN_CLK_HZ / `CDPIN_LOCK_SAMPLE_HZ,
	parameter CMD_W = `CDPIN_CMD_W
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_rstn,
	// asynchronous pins
	input wire i_mute,
	input wire i_command_data,
	input wire i_command_shift_clock,
	input wire i_command_latch_strobe,
	input wire i_sense_readout_clock,
	input wire i_wideband_vco_clock,
	// lock pin
	input wire i_lock_in,
	output reg o_lock_out_ff,
	output reg o_lock_oe_ff,
	// internal dsp signals on the core clock
	input wire i_frame_sync_good,
	input wire i_unlock_normal,
	input wire i_pick_normal,
	input wire i_correction_pointer,
	input wire [3:0] i_monitor_signal,
	input wire i_frame_reference_clock,
	input wire i_memory_overflow_flag,
	input wire i_sync_top_flag,
	input wire i_subcode_sync_pattern_a,
	input wire i_subcode_sync_pattern_b,
	input wire i_gated_subcode_sync,
	// status and clock pins
	output reg o_mute_ff,
	output reg o_sense_status_out_ff,
	output reg o_monitor_pin_a_ff,
	output reg o_monitor_pin_b_ff,
	output reg o_frame_sync_good_ff,
	output reg o_correction_pointer_out_ff,
	output reg o_subcode_sync_flag_ff,
	output reg o_quarter_clock_out_ff,
	output reg o_word_clock_out_ff,
	output reg o_two_thirds_clock_out_ff,
	// register port
	input wire [`CDPIN_ADDR_W-1:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata_ff,
	output reg o_irq_ff
);

	localparam SYNC_W = 7;
	localparam S_MUTE = 0;
	localparam S_DATA = 1;
	localparam S_SCLK = 2;
	localparam S_LATCH = 3;
	localparam S_SENSE = 4;
	localparam S_VCO = 5;
	localparam S_LOCK = 6;
	localparam [63:0] QUARTER_INC_FULL =
		(64'd2 * `CDPIN_QUARTER_HZ * 64'h100000000) / `CDPIN_CLK_HZ;
	localparam [63:0] WORD_INC_FULL =
		(64'd4 * `CDPIN_SAMPLE_RATE_HZ * 64'h100000000) / `CDPIN_CLK_HZ;
	localparam [`CDPIN_NCO_W-1:0] QUARTER_INC = QUARTER_INC_FULL[`CDPIN_NCO_W-1:0];
	localparam [`CDPIN_NCO_W-1:0] WORD_INC = WORD_INC_FULL[`CDPIN_NCO_W-1:0];
	localparam [31:0] LOCK_LAST = LOCK_SAMPLE_CYCLES - 1;

	// three-stage synchronisers with agree filter
	reg [SYNC_W-1:0] sync1_ff;
	reg [SYNC_W-1:0] sync2_ff;
	reg [SYNC_W-1:0] sync3_ff;
	reg [SYNC_W-1:0] filt_ff;
	wire [SYNC_W-1:0] nxt_filt;

	// command state
	wire [CMD_W-1:0] cmd_word;
	wire cmd_valid;
	reg [1:0] sel_a_ff;
	reg sel_b_ff;
	reg [1:0] sel_sync_pin_ff;
	reg [1:0] sel_pointer_ff;
	reg sel_word_clk_ff;
	reg wide_mode_ff;
	reg hold_sel_ff;

	// lock filter
	reg [31:0] lock_div_ff;
	reg [3:0] low_cnt_ff;
	reg lock_ind_ff;
	reg nxt_lock_ind;
	reg [3:0] nxt_low_cnt;
	reg lock_val_d_ff;
	wire lock_tick;
	wire lock_val;

	// clocks
	reg [`CDPIN_NCO_W-1:0] quarter_acc_ff;
	reg [`CDPIN_NCO_W-1:0] word_acc_ff;
	reg quarter_nco_ff;
	reg word_nco_ff;
	reg vco_d_ff;
	reg [1:0] vco_div_ff;
	reg [1:0] third_cnt_ff;
	wire [`CDPIN_NCO_W:0] quarter_sum;
	wire [`CDPIN_NCO_W:0] word_sum;

	// sense shifter
	reg [`CDPIN_SENSE_W-1:0] sense_sr_ff;
	reg sense_clk_d_ff;
	wire [`CDPIN_SENSE_W-1:0] sense_word;

	// interrupts and registers
	reg [`CDPIN_INT_W-1:0] int_status_ff;
	reg [`CDPIN_INT_W-1:0] int_enable_ff;
	reg [CMD_W-1:0] last_cmd_ff;
	reg subcode_d_ff;
	wire [`CDPIN_INT_W-1:0] int_event;
	wire [`CDPIN_INT_W-1:0] int_clear;
	wire [`CDPIN_INT_W-1:0] nxt_int_status;
	reg [31:0] nxt_rdata;

	function [0:0] pick3;
		input [1:0] sel;
		input normal;
		input mon;
		input alt;
		begin
			case (sel)
				`CDPIN_SEL_MON: pick3 = mon;
				`CDPIN_SEL_ALT: pick3 = alt;
				default: pick3 = normal;
			endcase
		end
	endfunction

	// a change counts once stages two and three agree
	assign nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff));

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin // R1
			sync1_ff <= {SYNC_W{1'b0}};
			sync2_ff <= {SYNC_W{1'b0}};
			sync3_ff <= {SYNC_W{1'b0}};
			filt_ff <= {SYNC_W{1'b0}};
		end else begin
			sync1_ff <= {i_lock_in, i_wideband_vco_clock, i_sense_readout_clock,
				i_command_latch_strobe, i_command_shift_clock, i_command_data, i_mute};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			filt_ff <= nxt_filt;
		end
	end

	cdpin_cmd_rx #(
		.CMD_W(CMD_W)
	) u_cmd_rx (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_command_data(filt_ff[S_DATA]),
		.i_command_shift_clock(filt_ff[S_SCLK]),
		.i_command_latch_strobe(filt_ff[S_LATCH]),
		.o_word_ff(cmd_word),
		.o_word_valid_ff(cmd_valid)
	);

	// command-held pin selections
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin // R17
			sel_a_ff <= `CDPIN_SEL_NORMAL;
			sel_b_ff <= 1'b0;
			sel_sync_pin_ff <= `CDPIN_SEL_NORMAL;
			sel_pointer_ff <= `CDPIN_SEL_NORMAL;
			sel_word_clk_ff <= 1'b0;
			wide_mode_ff <= 1'b0;
			hold_sel_ff <= 1'b0;
			last_cmd_ff <= {CMD_W{1'b0}};
		end else if (cmd_valid) begin
			last_cmd_ff <= cmd_word;
			if (cmd_word[`CDPIN_CMD_ADDR_MSB:`CDPIN_CMD_ADDR_LSB] == `CDPIN_CMD_SEL_ADDR) begin
				sel_a_ff <= cmd_word[`CDPIN_SEL_A_LSB+:2]; // R17
				sel_b_ff <= cmd_word[`CDPIN_SEL_B_BIT];
				sel_sync_pin_ff <= cmd_word[`CDPIN_SEL_SYNC_LSB+:2];
				sel_pointer_ff <= cmd_word[`CDPIN_SEL_POINTER_LSB+:2];
				sel_word_clk_ff <= cmd_word[`CDPIN_SEL_WORD_CLK_BIT];
			end
			if (cmd_word[`CDPIN_CMD_ADDR_MSB:`CDPIN_CMD_ADDR_LSB] == `CDPIN_CMD_MODE_ADDR) begin
				wide_mode_ff <= cmd_word[`CDPIN_MODE_WIDE_BIT];
				hold_sel_ff <= cmd_word[`CDPIN_MODE_HOLD_BIT];
			end
		end
	end

	// lock indicator
	assign lock_tick = (lock_div_ff == LOCK_LAST);

	always @* begin
		nxt_lock_ind = lock_ind_ff;
		nxt_low_cnt = low_cnt_ff;
		if (lock_tick) begin
			if (i_frame_sync_good) begin
				nxt_lock_ind = 1'b1; // R5
				nxt_low_cnt = 4'h0; // R16
			end else if (low_cnt_ff == `CDPIN_LOCK_LOW_SAMPLES - 4'h1) begin
				nxt_lock_ind = 1'b0; // R6
				nxt_low_cnt = `CDPIN_LOCK_LOW_SAMPLES;
			end else if (low_cnt_ff != `CDPIN_LOCK_LOW_SAMPLES) begin
				nxt_low_cnt = low_cnt_ff + 4'h1; // R6
			end
		end
	end

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lock_div_ff <= 32'h0;
			low_cnt_ff <= 4'h0;
			lock_ind_ff <= 1'b0;
		end else begin
			lock_div_ff <= lock_tick ? 32'h0 : lock_div_ff + 32'h1; // R5
			low_cnt_ff <= nxt_low_cnt;
			lock_ind_ff <= nxt_lock_ind;
		end
	end

	// held mode reads the pin instead of driving it
	assign lock_val = hold_sel_ff ? filt_ff[S_LOCK] : lock_ind_ff; // R7

	// derived clocks; nco jitter of one core cycle is the price of a 25 MHz base
	assign quarter_sum = {1'b0, quarter_acc_ff} + {1'b0, QUARTER_INC};
	assign word_sum = {1'b0, word_acc_ff} + {1'b0, WORD_INC};

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			quarter_acc_ff <= {`CDPIN_NCO_W{1'b0}};
			word_acc_ff <= {`CDPIN_NCO_W{1'b0}};
			quarter_nco_ff <= 1'b0;
			word_nco_ff <= 1'b0;
			vco_d_ff <= 1'b0;
			vco_div_ff <= 2'h0;
			third_cnt_ff <= 2'h0;
		end else begin
			quarter_acc_ff <= quarter_sum[`CDPIN_NCO_W-1:0];
			word_acc_ff <= word_sum[`CDPIN_NCO_W-1:0];
			if (quarter_sum[`CDPIN_NCO_W]) begin
				quarter_nco_ff <= ~quarter_nco_ff; // R13
			end
			if (word_sum[`CDPIN_NCO_W]) begin
				word_nco_ff <= ~word_nco_ff; // R14
			end
			vco_d_ff <= filt_ff[S_VCO];
			if (filt_ff[S_VCO] & ~vco_d_ff) begin
				vco_div_ff <= vco_div_ff + 2'h1; // R13
			end
			third_cnt_ff <= (third_cnt_ff == 2'h2) ? 2'h0 : third_cnt_ff + 2'h1; // R15
		end
	end

	// sense readout
	assign sense_word = {lock_val, i_frame_sync_good, o_subcode_sync_flag_ff,
		hold_sel_ff, wide_mode_ff, o_mute_ff, sel_word_clk_ff, 1'b0};

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sense_sr_ff <= {`CDPIN_SENSE_W{1'b0}};
			sense_clk_d_ff <= 1'b0;
		end else begin
			sense_clk_d_ff <= filt_ff[S_SENSE];
			if (cmd_valid) begin
				sense_sr_ff <= sense_word; // R4
			end else if (filt_ff[S_SENSE] & ~sense_clk_d_ff) begin
				sense_sr_ff <= {sense_sr_ff[`CDPIN_SENSE_W-2:0], 1'b0}; // R4
			end
		end
	end

	// interrupts: set wins over clear
	assign int_event[`CDPIN_INT_LOCK_GAIN] = lock_val & ~lock_val_d_ff;
	assign int_event[`CDPIN_INT_LOCK_LOSS] = ~lock_val & lock_val_d_ff;
	assign int_event[`CDPIN_INT_SUBCODE] = o_subcode_sync_flag_ff & ~subcode_d_ff;
	assign int_event[`CDPIN_INT_COMMAND] = cmd_valid;
	assign int_clear = (i_wr && i_addr == `CDPIN_ADDR_INT_CLEAR) ?
		i_wdata[`CDPIN_INT_W-1:0] : {`CDPIN_INT_W{1'b0}};
	assign nxt_int_status = (int_status_ff & ~int_clear) | int_event;

	always @* begin
		nxt_rdata = 32'h0;
		case (i_addr)
			`CDPIN_ADDR_STATUS: nxt_rdata = {24'h0, sense_word};
			`CDPIN_ADDR_INT_STATUS: nxt_rdata = {28'h0, int_status_ff};
			`CDPIN_ADDR_INT_ENABLE: nxt_rdata = {28'h0, int_enable_ff};
			`CDPIN_ADDR_LAST_CMD: nxt_rdata = {8'h0, last_cmd_ff};
			default: nxt_rdata = 32'h0;
		endcase
	end

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			int_status_ff <= {`CDPIN_INT_W{1'b0}};
			int_enable_ff <= {`CDPIN_INT_W{1'b0}};
			lock_val_d_ff <= 1'b0;
			subcode_d_ff <= 1'b0;
			o_rdata_ff <= 32'h0;
			o_irq_ff <= 1'b0;
		end else begin
			lock_val_d_ff <= lock_val;
			subcode_d_ff <= o_subcode_sync_flag_ff;
			int_status_ff <= nxt_int_status;
			if (i_wr && i_addr == `CDPIN_ADDR_INT_ENABLE) begin
				int_enable_ff <= i_wdata[`CDPIN_INT_W-1:0];
			end
			o_rdata_ff <= i_rd ? nxt_rdata : 32'h0;
			o_irq_ff <= |(nxt_int_status & int_enable_ff);
		end
	end

	// registered pin outputs
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin // R1
			o_lock_out_ff <= 1'b0;
			o_lock_oe_ff <= 1'b0;
			o_mute_ff <= 1'b0;
			o_sense_status_out_ff <= 1'b0;
			o_monitor_pin_a_ff <= 1'b0;
			o_monitor_pin_b_ff <= 1'b0;
			o_frame_sync_good_ff <= 1'b0;
			o_correction_pointer_out_ff <= 1'b0;
			o_subcode_sync_flag_ff <= 1'b0;
			o_quarter_clock_out_ff <= 1'b0;
			o_word_clock_out_ff <= 1'b0;
			o_two_thirds_clock_out_ff <= 1'b0;
		end else begin
			o_lock_out_ff <= lock_ind_ff; // R5
			o_lock_oe_ff <= ~hold_sel_ff; // R7
			o_mute_ff <= filt_ff[S_MUTE]; // R2
			o_sense_status_out_ff <= sense_sr_ff[`CDPIN_SENSE_W-1]; // R4
			o_monitor_pin_a_ff <= pick3(sel_a_ff, i_unlock_normal,
				i_monitor_signal[0], i_frame_reference_clock); // R8
			o_monitor_pin_b_ff <= sel_b_ff ? i_monitor_signal[1] : i_pick_normal; // R9
			o_frame_sync_good_ff <= pick3(sel_sync_pin_ff, i_frame_sync_good,
				i_monitor_signal[2], i_memory_overflow_flag); // R10
			o_correction_pointer_out_ff <= pick3(sel_pointer_ff, i_correction_pointer,
				i_monitor_signal[3], i_sync_top_flag); // R11
			o_subcode_sync_flag_ff <= i_subcode_sync_pattern_a | i_subcode_sync_pattern_b; // R12
			o_quarter_clock_out_ff <= wide_mode_ff ? vco_div_ff[1] : quarter_nco_ff; // R13
			o_word_clock_out_ff <= sel_word_clk_ff ? i_gated_subcode_sync : word_nco_ff; // R14
			o_two_thirds_clock_out_ff <= (third_cnt_ff != 2'h2); // R15
		end
	end

endmodule

// ---- cdpin_regs.vh ----
// Purpose: constants for the cd dsp pin control and status block
// Assumes: 25 MHz core clock, plain register port with byte addresses
// Notes: command word is 24 bits, address nibble on top
// How it works
// R1: every flip-flop is held in reset while the chip reset input is low.
// R2: the mute output follows the synchronised mute input, high meaning mute on.
// R3: command bits shift in on the shift clock and the word is taken on the latch strobe's fall.
// R4: sense data leave on the sense output, one bit per rising edge of the host readout clock.
// R5: frame-sync-good is sampled at 460 Hz and a high sample drives the lock output high.
// R6: the lock output falls only after eight consecutive low samples.
// R7: when the external hold select setting is 1 the lock pin becomes an input.
// R8: monitor pin a shows its normal signal, monitor signal 0 or the frame reference clock.
// R9: monitor pin b shows its normal signal or monitor signal 1.
// R10: the frame-sync-good pin shows that signal, monitor signal 2 or the memory overflow flag.
// R11: the correction pointer pin shows the pointer, monitor signal 3 or the sync top flag.
// R12: the subcode sync flag goes high when either subcode sync pattern is detected.
// R13: the quarter clock runs at 4.2336 MHz, or is the wideband vco clock over four in wide modes.
// R14: the word clock runs at twice the sample rate, or carries gated subcode sync when selected.
// R15: the two-thirds output divides the crystal clock in a two-of-three pattern.
// R16: any high sample of frame-sync-good clears the consecutive-low counter.
// R17: pin selections hold their commanded value until a new command and reset to default.
`ifndef CDPIN_REGS_VH
`define CDPIN_REGS_VH

`define CDPIN_CLK_HZ 25000000
`define CDPIN_LOCK_SAMPLE_HZ 460
`define CDPIN_LOCK_LOW_SAMPLES 4'h8
`define CDPIN_QUARTER_HZ 4233600
`define CDPIN_SAMPLE_RATE_HZ 44100
`define CDPIN_NCO_W 32

`define CDPIN_CMD_W 24
`define CDPIN_CMD_ADDR_MSB 23
`define CDPIN_CMD_ADDR_LSB 20
`define CDPIN_CMD_SEL_ADDR 4'ha
`define CDPIN_CMD_MODE_ADDR 4'hb

// selection command field positions
`define CDPIN_SEL_A_LSB 0
`define CDPIN_SEL_B_BIT 2
`define CDPIN_SEL_SYNC_LSB 3
`define CDPIN_SEL_POINTER_LSB 5
`define CDPIN_SEL_WORD_CLK_BIT 7
// mode command field positions
`define CDPIN_MODE_WIDE_BIT 0
`define CDPIN_MODE_HOLD_BIT 1

`define CDPIN_SEL_NORMAL 2'h0
`define CDPIN_SEL_MON 2'h1
`define CDPIN_SEL_ALT 2'h2

`define CDPIN_ADDR_W 8
`define CDPIN_ADDR_STATUS 8'h00
`define CDPIN_ADDR_INT_STATUS 8'h04
`define CDPIN_ADDR_INT_CLEAR 8'h08
`define CDPIN_ADDR_INT_ENABLE 8'h0c
`define CDPIN_ADDR_LAST_CMD 8'h10

`define CDPIN_INT_W 4
`define CDPIN_INT_LOCK_GAIN 0
`define CDPIN_INT_LOCK_LOSS 1
`define CDPIN_INT_SUBCODE 2
`define CDPIN_INT_COMMAND 3

`define CDPIN_SENSE_W 8

`endif

// ---- cdpin_cmd_rx.v ----
// Purpose: serial command receiver, shift then latch
// Assumes: inputs already synchronised and filtered to the core clock
// Notes: a word shorter than the command width keeps older upper bits
`timescale 1ns/1ps
`include "cdpin_regs.vh"

module cdpin_cmd_rx #(
	parameter CMD_W = `CDPIN_CMD_W
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_rstn,
	// filtered serial lines
	input wire i_command_data,
	input wire i_command_shift_clock,
	input wire i_command_latch_strobe,
	// assembled word
	output reg [CMD_W-1:0] o_word_ff,
	output reg o_word_valid_ff
);

	reg shift_clk_d_ff;
	reg latch_d_ff;
	reg [CMD_W-1:0] shift_ff;
	wire shift_rise;
	wire latch_fall;

	assign shift_rise = i_command_shift_clock & ~shift_clk_d_ff;
	assign latch_fall = ~i_command_latch_strobe & latch_d_ff;

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin // R1
			shift_clk_d_ff <= 1'b1;
			// matches the filtered idle level, so no false latch after reset
			latch_d_ff <= 1'b0;
			shift_ff <= {CMD_W{1'b0}};
			o_word_ff <= {CMD_W{1'b0}};
			o_word_valid_ff <= 1'b0;
		end else begin
			shift_clk_d_ff <= i_command_shift_clock;
			latch_d_ff <= i_command_latch_strobe;
			if (shift_rise) begin
				shift_ff <= {shift_ff[CMD_W-2:0], i_command_data}; // R3
			end
			o_word_valid_ff <= latch_fall;
			if (latch_fall) begin
				o_word_ff <= shift_ff; // R3
			end
		end
	end

endmodule

// ---- cdpin_host.sv ----
// Purpose: host model for the serial command and sense lines
// Assumes: four core cycles per level clear the input filter
// Notes: shift clock idles low, data idles inverted
`timescale 1ns/1ps
module cdpin_host (
	// clock and sense
	input wire i_clk,
	input wire i_sense,
	// serial lines
	output logic o_data,
	output logic o_shift,
	output logic o_latch,
	output logic o_rdclk
);
	initial begin
		o_data = 1'b0;
		o_shift = 1'b0;
		o_latch = 1'b0;
		o_rdclk = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// msb first; long levels since short pulses may be lost
	task automatic send(input [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			o_data <= w[i];
			wt(4);
			o_shift <= 1'b1;
			wt(4);
			o_shift <= 1'b0;
		end
		o_latch <= 1'b1;
		o_data <= ~w[0];
		wt(4);
		o_latch <= 1'b0;
		wt(8);
	endtask
	task automatic read_sense(output [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			@(negedge i_clk);
			v[i] = i_sense;
			@(posedge i_clk);
			o_rdclk <= 1'b1;
			wt(8);
			o_rdclk <= 1'b0;
			wt(4);
		end
	endtask
endmodule

// ---- cdpin_top_assertions.sv ----
// Purpose: port checks of the cd pin status block
// Assumes: one core clock, active low async reset
// Notes: lock bounds scale with the sample period
`timescale 1ns/1ps
module cdpin_chk #(
	parameter LOCK_SAMPLE_CYCLES = 16
) (
	// clock, reset and inputs
	input wire i_core_clk,
	input wire i_rstn,
	input wire i_mute,
	input wire i_rd,
	input wire [7:0] i_addr,
	input wire i_frame_sync_good,
	input wire i_subcode_sync_pattern_a,
	input wire i_subcode_sync_pattern_b,
	// outputs
	input wire o_lock_out_ff,
	input wire o_lock_oe_ff,
	input wire o_mute_ff,
	input wire o_irq_ff,
	input wire o_subcode_sync_flag_ff,
	input wire o_two_thirds_clock_out_ff,
	input wire [31:0] o_rdata_ff
);
	int low_run_ff;
	// outputs are unknown until the first edge inside reset
	logic in_reset_ff = 1'b0;
	always @(posedge i_core_clk) begin
		in_reset_ff <= !i_rstn;
	end
	// cycles since frame sync good was last high
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			low_run_ff <= 0;
		end else begin
			low_run_ff <= i_frame_sync_good ? 0 : low_run_ff + 1;
		end
	end
	default clocking dc @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	a_reset_quiet: assert property (disable iff (1'b0) !i_rstn && in_reset_ff |->
		!o_lock_out_ff && !o_lock_oe_ff && !o_mute_ff && !o_irq_ff) else $error("set in reset");
	a_mute_on: assert property ($rose(i_mute) |-> ##[2:6] o_mute_ff)
		else $error("mute late");
	a_mute_off: assert property (!i_mute [*6] |-> !o_mute_ff)
		else $error("mute stuck");
	a_subcode_flag: assert property (1'b1 |=> o_subcode_sync_flag_ff ==
		($past(i_subcode_sync_pattern_a) || $past(i_subcode_sync_pattern_b))) else $error("scf");
	a_lock_rise: assert property ($rose(o_lock_out_ff) && o_lock_oe_ff |->
		low_run_ff <= LOCK_SAMPLE_CYCLES + 4) else $error("lock rose");
	a_lock_drop: assert property ($fell(o_lock_out_ff) && o_lock_oe_ff |->
		low_run_ff >= 7 * LOCK_SAMPLE_CYCLES) else $error("lock fell early");
	a_two_thirds: assert property ($rose(o_two_thirds_clock_out_ff) |=>
		o_two_thirds_clock_out_ff ##1 !o_two_thirds_clock_out_ff ##1 o_two_thirds_clock_out_ff)
		else $error("two thirds pattern");
	a_rdata_idle: assert property (!i_rd |=> o_rdata_ff == 32'h0) else $error("rdata idle");
	a_unmapped_zero: assert property (i_rd && i_addr == 8'h14 |=> o_rdata_ff == 32'h0)
		else $error("unmapped read");
	c_lock_loss: cover property ($fell(o_lock_out_ff));
	c_irq_up: cover property ($rose(o_irq_ff));
	c_hold_in: cover property ($fell(o_lock_oe_ff));
endmodule
bind cdpin_top cdpin_chk #(.LOCK_SAMPLE_CYCLES(LOCK_SAMPLE_CYCLES)) cdpin_chk_inst (.i_core_clk,
	.i_rstn, .i_mute, .i_rd, .i_addr, .i_frame_sync_good, .i_subcode_sync_pattern_a,
	.i_subcode_sync_pattern_b, .o_lock_out_ff, .o_lock_oe_ff, .o_mute_ff, .o_irq_ff,
	.o_subcode_sync_flag_ff, .o_two_thirds_clock_out_ff, .o_rdata_ff);

// ---- cdpin_top_test.sv ----
// Purpose: self-checking bench for the cd pin status block
// Assumes: lock sample period cut to sixteen cycles
// Notes: host model owns the serial lines
`timescale 1ns/1ps
`include "cdpin_regs.vh"
module cdpin_top_test;
	localparam int LSC = 16;
	localparam int QX = `CDPIN_QUARTER_HZ * 3 / (`CDPIN_CLK_HZ / 1000);
	localparam int WX = `CDPIN_SAMPLE_RATE_HZ * 6 / (`CDPIN_CLK_HZ / 1000);
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic mute = 1'b0;
	logic lock_in = 1'b0;
	logic sync_good = 1'b0;
	logic unl = 1'b0;
	logic pick = 1'b0;
	logic ptr = 1'b0;
	logic [3:0] mon = 4'h0;
	logic fref = 1'b0;
	logic ovf = 1'b0;
	logic stop = 1'b0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic gsub = 1'b0;
	logic [3:0] vc = 4'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] sv;
	wire hd, hs, hl, hr, lock_out, lock_oe, mute_o, sense, pin_a, pin_b, pin_g, pin_c;
	wire scf, qclk, wclk, irq;
	wire [31:0] rdata;
	int fail_count = 0;
	int comparisons = 0;
	int qn = 0;
	int wn = 0;
	cdpin_top #(.LOCK_SAMPLE_CYCLES(LSC)) cdpin_top_inst (.i_core_clk(clk), .i_rstn(rstn),
		.i_mute(mute), .i_command_data(hd), .i_command_shift_clock(hs),
		.i_command_latch_strobe(hl), .i_sense_readout_clock(hr), .i_wideband_vco_clock(vc[3]),
		.i_lock_in(lock_in), .o_lock_out_ff(lock_out), .o_lock_oe_ff(lock_oe),
		.i_frame_sync_good(sync_good), .i_unlock_normal(unl), .i_pick_normal(pick),
		.i_correction_pointer(ptr), .i_monitor_signal(mon), .i_frame_reference_clock(fref),
		.i_memory_overflow_flag(ovf), .i_sync_top_flag(stop), .i_subcode_sync_pattern_a(pa),
		.i_subcode_sync_pattern_b(pb), .i_gated_subcode_sync(gsub), .o_mute_ff(mute_o),
		.o_sense_status_out_ff(sense), .o_monitor_pin_a_ff(pin_a), .o_monitor_pin_b_ff(pin_b),
		.o_frame_sync_good_ff(pin_g), .o_correction_pointer_out_ff(pin_c),
		.o_subcode_sync_flag_ff(scf), .o_quarter_clock_out_ff(qclk), .o_word_clock_out_ff(wclk),
		.o_two_thirds_clock_out_ff(), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
		.i_rd(rd_s), .o_rdata_ff(rdata), .o_irq_ff(irq));
	cdpin_host cdpin_host_inst (.i_clk(clk), .i_sense(sense), .o_data(hd), .o_shift(hs),
		.o_latch(hl), .o_rdclk(hr));
	initial begin
		forever #20 clk = ~clk;
	end
	// free running stand-in for the wideband vco, a sixteenth of the core rate
	always @(posedge clk) vc <= vc + 4'h1;
	always @(posedge qclk) qn++;
	always @(posedge wclk) wn++;
	task automatic chk(input [31:0] seen, input [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rdc(input [7:0] a, input [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up;
	end
	initial begin
		nap(10);
		chk({lock_out, lock_oe, mute_o, irq}, 4'h0);
		@(posedge clk);
		rstn <= 1'b1;
		rdc(8'h0c, 32'h0);
		rdc(8'h04, 32'h0);
		rdc(8'h00, 32'h0);
		for (int k = 2; k >= 0; k--) begin
			@(posedge clk);
			cdpin_host_inst.send(24'(32'ha00000 | k | k << 3 | k << 5 | (k == 1) << 2));
			for (int p = 0; p < 2; p++) begin
				unl <= p[0];
				pick <= p[0];
				sync_good <= p[0];
				ptr <= p[0];
				mon <= {4{p[0] ^ (k == 1)}};
				{fref, ovf, stop} <= {3{p[0] ^ (k == 2)}};
				nap(4);
				chk(pin_a, p[0] ^ (k != 0));
				chk(pin_b, p[0] ^ (k == 1));
				chk(pin_g, p[0] ^ (k != 0));
				chk(pin_c, p[0] ^ (k != 0));
				@(posedge clk);
			end
		end
		sync_good <= 1'b0;
		nap(12 * LSC);
		chk(lock_out, 1'b0);
		@(posedge clk);
		sync_good <= 1'b1;
		nap(2 * LSC + 4);
		chk({lock_out, lock_oe}, 2'b11);
		@(posedge clk);
		mute <= 1'b1;
		cdpin_host_inst.send(24'hb00000);
		nap(0);
		chk(mute_o, 1'b1);
		cdpin_host_inst.read_sense(sv);
		chk(sv, 8'hc4);
		rdc(8'h00, 32'hc4);
		@(posedge clk);
		sync_good <= 1'b0;
		nap(6 * LSC);
		chk(lock_out, 1'b1);
		@(posedge clk);
		sync_good <= 1'b1;
		nap(2 * LSC);
		@(posedge clk);
		sync_good <= 1'b0;
		nap(6 * LSC);
		chk(lock_out, 1'b1);
		nap(4 * LSC);
		chk(lock_out, 1'b0);
		qn = 0;
		wn = 0;
		nap(3000);
		chk(qn >= QX - 1 && qn <= QX + 2, 1'b1);
		chk(wn >= WX - 1 && wn <= WX + 2, 1'b1);
		@(posedge clk);
		cdpin_host_inst.send(24'hb00001);
		nap(0);
		qn = 0;
		nap(1024);
		chk(qn >= 15 && qn <= 17, 1'b1);
		@(posedge clk);
		cdpin_host_inst.send(24'ha00080);
		for (int g = 1; g >= 0; g--) begin
			gsub <= g[0];
			nap(3);
			chk(wclk, g[0]);
			@(posedge clk);
		end
		lock_in <= 1'b1;
		cdpin_host_inst.send(24'hb00002);
		nap(0);
		chk(lock_oe, 1'b0);
		rdc(8'h00, 32'h96);
		@(posedge clk);
		lock_in <= 1'b0;
		nap(6);
		rdc(8'h00, 32'h16);
		rdc(8'h10, 32'hb00002);
		wr(8'h08, 32'hf);
		rdc(8'h04, 32'h0);
		wr(8'h0c, 32'h4);
		rdc(8'h0c, 32'h4);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			{pb, pa} <= s ? 2'b10 : 2'b01;
			nap(1);
			chk(scf, 1'b1);
			@(posedge clk);
			{pb, pa} <= 2'b00;
			nap(2);
			chk({scf, irq}, 2'b01);
		end
		rdc(8'h04, 32'h4);
		wr(8'h0c, 32'h0);
		nap(1);
		chk(irq, 1'b0);
		wr(8'h0c, 32'h4);
		nap(1);
		chk(irq, 1'b1);
		wr(8'h08, 32'h4);
		nap(1);
		chk(irq, 1'b0);
		wr(8'h04, 32'hf);
		rdc(8'h04, 32'h0);
		rdc(8'h14, 32'h0);
		@(posedge clk);
		mute <= 1'b0;
		nap(6);
		chk(mute_o, 1'b0);
		wrap_up;
	end
endmodule
